// File: logic/mcsf_bank.sv
// Purpose: Status flag variables of a motor controller and its stop command.
// Assumes: Parsed command strobes arrive synchronous to clock.
// Notes: Each variable goes out as two bytes, low byte first.
//        A request made while a word is pending or in flight is dropped without notice.
// Summary of operation
// - Stop command forces target speed to zero and arms safe-start if enabled.
// - Stopping keeps deceleration limits; restart waits for safe-start conditions.
// - Requested variables are sent as 16 bits, two bytes, low byte first.
// - Live error word: bits 0..9 are the current stopping errors, upper reserved.
// - Motor is driven only while the live error word is zero.
// - Sticky error log mirrors the live layout and holds every error seen.
// - Reading the sticky error log returns it, then clears every bit but the errors present in the read cycle.
// - Serial error log latches bits 1..5 and clears when read, keeping only pulses of the read cycle.
// - Limit status word reflects live restricting conditions, not history.
// - Limit bits: blocked, temperature, max, start, ramp, four kills, USB kill.
`timescale 1ns/1ps
`default_nettype none
`include "mcsf_defines.svh"
module mcsf_bank
  import mcsf_pkg::*;
(
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Commands from the command parser.
  input  wire logic        stop_cmd,
  input  wire logic        go_cmd,
  input  wire logic        speed_cmd,
  input  wire logic [15:0] speed_value,
  input  wire logic        safe_start_enable,
  input  wire logic        safe_start_cond_met,
  input  wire logic [15:0] decel_step,
  // Variable read request and byte answer.
  input  wire logic        get_var,
  input  wire logic [7:0]  get_var_id,
  input  wire logic        tx_ready,
  output logic             tx_valid,
  output logic [7:0]       tx_byte,
  output logic             var_unknown,
  // Error and serial error sources, live levels and pulses.
  input  wire logic [9:0]  error_sources,
  input  wire logic [5:1]  serial_error_pulse,
  // Limiting causes, live levels.
  input  wire logic        temp_reducing,
  input  wire logic        max_speed_clamp,
  input  wire logic        start_speed_clamp,
  input  wire logic [3:0]  channel_kill,
  input  wire logic        usb_kill,
  // Motor drive.
  output logic             motor_enable,
  output logic [15:0]      target_speed,
  output logic [15:0]      motor_speed
);
  mcsf_word_type     live_err_q;
  mcsf_word_type     sticky_err_q;
  mcsf_word_type     sticky_ser_q;
  mcsf_word_type     limit_q;
  mcsf_word_type     err_now;
  mcsf_word_type     ser_now;
  logic              safe_viol_q;
  logic              tx_valid_q;
  logic [7:0]        tx_byte_q;
  logic              var_unknown_q;
  logic              motor_enable_q;
  logic [15:0]       target_q;
  logic [15:0]       speed_q;
  logic [7:0]        high_byte_q;
  mcsf_tx_state_type tx_state_q;
  logic              read_sticky_err;
  logic              read_sticky_ser;
  logic              id_known;
  mcsf_word_type     sel_word;
  logic              pend_q;
  logic [1:0]        pend_idx_q;
  logic              take_req;
  mcsf_word_type     limit_now;
  mcsf_rd_if         snap ();

  mcsf_snap_mem #(
    .DEPTH (`MCSF_MEM_DEPTH)
  ) u_snap (
    .clock (clock),
    .rst_n (rst_n),
    .port  (snap)
  );

  // Safe-start violation is armed by stop and cleared by go.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      safe_viol_q <= 1'b1;
    else if (stop_cmd && safe_start_enable)
      safe_viol_q <= 1'b1;
    else if (!safe_start_enable)
      safe_viol_q <= 1'b0;
    else if (go_cmd && safe_start_cond_met)
      safe_viol_q <= 1'b0;
  end

  always_comb
  begin
    err_now = {6'h00, error_sources};
    err_now[`MCSF_ERR_SAFE_START] = safe_viol_q;
    err_now[`MCSF_ERR_SERIAL] = error_sources[`MCSF_ERR_SERIAL] | (|serial_error_pulse);
    err_now = err_now & `MCSF_ERR_USED_MASK;
    ser_now = {10'h000, serial_error_pulse, 1'b0} & `MCSF_SER_USED_MASK;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      live_err_q <= `MCSF_RESET_WORD;
    else
      live_err_q <= err_now;
  end

  // A read clears the log, but an error in the same cycle survives the clear.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      sticky_err_q <= `MCSF_RESET_WORD;
    else if (read_sticky_err)
      sticky_err_q <= err_now;
    else
      sticky_err_q <= sticky_err_q | err_now;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      sticky_ser_q <= `MCSF_RESET_WORD;
    else if (read_sticky_ser)
      sticky_ser_q <= ser_now;
    else
      sticky_ser_q <= sticky_ser_q | ser_now;
  end

  // Limiting causes are live levels, so the word is rebuilt every cycle with no memory.
  always_comb
  begin
    limit_now                          = `MCSF_RESET_WORD;
    limit_now[`MCSF_LIM_BLOCKED]       = (err_now != 16'h0000);
    limit_now[`MCSF_LIM_TEMP]          = temp_reducing;
    limit_now[`MCSF_LIM_MAX_SPEED]     = max_speed_clamp;
    limit_now[`MCSF_LIM_START_SPEED]   = start_speed_clamp;
    limit_now[`MCSF_LIM_RAMP_LAG]      = (speed_q != target_q);
    limit_now[`MCSF_LIM_KILL_LSB +: 4] = channel_kill;
    limit_now[`MCSF_LIM_USB_KILL]      = usb_kill;
    limit_now                          = limit_now & `MCSF_LIM_USED_MASK;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      limit_q <= `MCSF_RESET_WORD;
    else
      limit_q <= limit_now;
  end

  // Motor runs only from a clean error word.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      motor_enable_q <= 1'b0;
    else
      motor_enable_q <= (err_now == 16'h0000);
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      target_q <= `MCSF_SPEED_ZERO;
    else if (stop_cmd)
      target_q <= `MCSF_SPEED_ZERO;
    else if (speed_cmd)
      target_q <= speed_value;
  end

  // Speed follows target; a drop is limited to decel_step per cycle, zero means no limit.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      speed_q <= `MCSF_SPEED_ZERO;
    else if (!motor_enable_q && target_q != 16'h0000)
      speed_q <= speed_q;
    else if (speed_q > target_q && decel_step != 16'h0000 && (speed_q - target_q) > decel_step)
      speed_q <= speed_q - decel_step;
    else
      speed_q <= target_q;
  end

  // Variable selection and reporting.
  always_comb
  begin
    id_known = (get_var_id <= `MCSF_OFF_LIMIT);
    case (get_var_id)
      `MCSF_OFF_LIVE_ERR:   sel_word = live_err_q;
      `MCSF_OFF_STICKY_ERR: sel_word = sticky_err_q;
      `MCSF_OFF_STICKY_SER: sel_word = sticky_ser_q;
      `MCSF_OFF_LIMIT:      sel_word = limit_q;
      default:              sel_word = 16'h0000;
    endcase
  end

  // A request is taken only with nothing pending or in flight; a held or early request
  // would otherwise clear a log whose old value is never sent.
  assign take_req = get_var && (tx_state_q == MCSF_IDLE) && !pend_q;
  assign read_sticky_err = take_req && (get_var_id == `MCSF_OFF_STICKY_ERR);
  assign read_sticky_ser = take_req && (get_var_id == `MCSF_OFF_STICKY_SER);
  assign snap.wr_en = take_req && id_known;
  assign snap.wr_idx = get_var_id[1:0];
  assign snap.wr_data = sel_word;
  assign snap.rd_idx = pend_idx_q;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      var_unknown_q <= 1'b0;
    else
      var_unknown_q <= take_req && !id_known;
  end

  // Snapshot is written on accept; the pending cycle covers the store's registered read.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend_q     <= 1'b0;
      pend_idx_q <= 2'h0;
    end
    else
    begin
      pend_q <= take_req && id_known;
      if (take_req && id_known)
        pend_idx_q <= get_var_id[1:0];
    end
  end

  // Sequencer: pending, low byte, high byte, each byte step moved on by the sink's ready.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      tx_state_q <= MCSF_IDLE;
    else
    begin
      case (tx_state_q)
        MCSF_IDLE:
        begin
          if (pend_q)
            tx_state_q <= MCSF_LOW;
        end
        MCSF_LOW:
        begin
          if (tx_valid_q && tx_ready)
            tx_state_q <= MCSF_HIGH;
        end
        MCSF_HIGH:
        begin
          if (tx_ready)
            tx_state_q <= MCSF_IDLE;
        end
        default:
          tx_state_q <= MCSF_IDLE;
      endcase
    end
  end

  // Valid stands across both bytes so the sink sees one unbroken word.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      tx_valid_q <= 1'b0;
    else if (tx_state_q == MCSF_LOW && !tx_valid_q)
      tx_valid_q <= 1'b1;
    else if (tx_state_q == MCSF_HIGH && tx_ready)
      tx_valid_q <= 1'b0;
  end

  // The high byte is parked at load time, so a later store write cannot tear the word.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_byte_q   <= 8'h00;
      high_byte_q <= 8'h00;
    end
    else if (tx_state_q == MCSF_LOW && !tx_valid_q)
    begin
      tx_byte_q   <= snap.rd_data[7:0];
      high_byte_q <= snap.rd_data[15:8];
    end
    else if (tx_state_q == MCSF_LOW && tx_ready)
      tx_byte_q <= high_byte_q;
  end

  assign tx_valid = tx_valid_q;
  assign tx_byte = tx_byte_q;
  assign var_unknown = var_unknown_q;
  assign motor_enable = motor_enable_q;
  assign target_speed = target_q;
  assign motor_speed = speed_q;
endmodule
`default_nettype wire

// File: logic/mcsf_defines.svh
// Purpose: Constants of the motor controller status flag bank.
// Assumes: Variables are 16 bits wide and addressed by a small index.
// Notes: Offsets are variable indices on the command link.
`ifndef MCSF_DEFINES_SVH
`define MCSF_DEFINES_SVH
`define MCSF_OFF_LIVE_ERR    8'h00
`define MCSF_OFF_STICKY_ERR  8'h01
`define MCSF_OFF_STICKY_SER  8'h02
`define MCSF_OFF_LIMIT       8'h03
`define MCSF_ERR_USED_MASK   16'h03ff
`define MCSF_SER_USED_MASK   16'h003e
`define MCSF_LIM_USED_MASK   16'h03ff
`define MCSF_ERR_SAFE_START  0
`define MCSF_ERR_SERIAL      2
`define MCSF_SER_FORMAT      4
`define MCSF_LIM_BLOCKED     0
`define MCSF_LIM_TEMP        1
`define MCSF_LIM_MAX_SPEED   2
`define MCSF_LIM_START_SPEED 3
`define MCSF_LIM_RAMP_LAG    4
`define MCSF_LIM_KILL_LSB    5
`define MCSF_LIM_USB_KILL    9
`define MCSF_RESET_WORD      16'h0000
`define MCSF_SPEED_ZERO      16'h0000
`define MCSF_MEM_DEPTH       4
`endif

// File: logic/mcsf_pkg.sv
// Purpose: Types shared by the status flag bank.
// Assumes: Nothing beyond the defines header.
// Notes: Holds types only.
package mcsf_pkg;
  typedef logic [15:0] mcsf_word_type;
  typedef enum logic [1:0] {MCSF_IDLE, MCSF_LOW, MCSF_HIGH} mcsf_tx_state_type;
endpackage

// File: logic/mcsf_rd_if.sv
// Purpose: Read port between the bank and its snapshot store.
// Assumes: One clock.
// Notes: Read data are registered in the store.
`timescale 1ns/1ps
`default_nettype none
interface mcsf_rd_if;
  logic        wr_en;
  logic [1:0]  wr_idx;
  logic [15:0] wr_data;
  logic [1:0]  rd_idx;
  logic [15:0] rd_data;
  modport bank  (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
  modport store (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface
`default_nettype wire

// File: logic/mcsf_snap_mem.sv
// Purpose: Small word store holding the last value reported per variable.
// Assumes: Synchronous write and registered read.
// Notes: Depth is a parameter.
`timescale 1ns/1ps
`default_nettype none
module mcsf_snap_mem
  import mcsf_pkg::*;
#(
  parameter int DEPTH = 4
)(
  // Clock and reset.
  input  wire logic clock,
  input  wire logic rst_n,
  // Access port.
  mcsf_rd_if.store  port
);
  mcsf_word_type mem_q [DEPTH];
  mcsf_word_type rd_q;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= 16'h0000;
    end
    else if (port.wr_en)
      mem_q[port.wr_idx] <= port.wr_data;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rd_q <= 16'h0000;
    else
      rd_q <= mem_q[port.rd_idx];
  end

  assign port.rd_data = rd_q;
endmodule
`default_nettype wire

// File: dv/mcsf_bank_properties.sv
// Purpose: Port timing properties of the status flag bank.
// Assumes: Bound into mcsf_bank.
// Notes: Drive enable lags the error inputs by one edge.
`timescale 1ns/1ps
`default_nettype none
module mcsf_bank_properties (
  // Clock and reset.
  input wire logic        clock,
  input wire logic        rst_n,
  // Watched ports.
  input wire logic        stop_cmd,
  input wire logic        safe_start_enable,
  input wire logic [15:0] decel_step,
  input wire logic        get_var,
  input wire logic [7:0]  get_var_id,
  input wire logic        tx_ready,
  input wire logic        tx_valid,
  input wire logic [7:0]  tx_byte,
  input wire logic        var_unknown,
  input wire logic [9:0]  error_sources,
  input wire logic        motor_enable,
  input wire logic [15:0] target_speed,
  input wire logic [15:0] motor_speed
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  a_stop_zero: assert property (stop_cmd |=> target_speed == 16'h0000)
    else $error("target kept after stop");
  a_stop_holds_off: assert property (stop_cmd && safe_start_enable |-> ##2 !motor_enable)
    else $error("drive after stop");
  a_decel_bound: assert property (decel_step != 16'h0000 |=>
    {1'b0, $past(motor_speed)} <= {1'b0, motor_speed} + {1'b0, $past(decel_step)})
    else $error("speed fell too fast");
  a_answer_lag: assert property ($rose(tx_valid) |-> $past(get_var, 3))
    else $error("answer lag wrong");
  a_byte_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
    else $error("byte not held");
  a_second_byte: assert property ($rose(tx_valid) && tx_ready |=> tx_valid)
    else $error("high byte missing");
  a_unknown_id: assert property (var_unknown |->
    ($past(get_var) && $past(get_var_id) > 8'h03) ##1 !tx_valid [*3])
    else $error("bad unknown id pulse");
  a_drive_clear: assert property (motor_enable |-> ($past(error_sources) & 10'h3fe) == 10'h000)
    else $error("drive while error");
  // Tracks which half of a word is on the link; every word has bits 10 to 15 reserved.
  logic hi_half_q;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      hi_half_q <= 1'b0;
    else if (tx_valid && tx_ready)
      hi_half_q <= !hi_half_q;
  end
  a_reserved_high: assert property (tx_valid && hi_half_q |-> tx_byte[7:2] == 6'h00)
    else $error("reserved bit set");
endmodule
bind mcsf_bank mcsf_bank_properties mcsf_bank_properties_i (.clock, .rst_n, .stop_cmd, .safe_start_enable,
  .decel_step, .get_var, .get_var_id, .tx_ready, .tx_valid, .tx_byte, .var_unknown, .error_sources,
  .motor_enable, .target_speed, .motor_speed);
`default_nettype wire

// File: dv/mcsf_host_model.sv
// Purpose: Host byte sink of the variable link.
// Assumes: Low byte of a variable comes first.
// Notes: Ready stalls at random so held bytes are exercised.
`timescale 1ns/1ps
`default_nettype none
module mcsf_host_model (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Byte link and word out.
  input  wire logic        tx_valid,
  input  wire logic [7:0]  tx_byte,
  input  wire logic        stall,
  output logic             tx_ready,
  output logic [15:0]      word,
  output int               n_words
);
  logic hi_q;
  assign tx_ready = !stall;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hi_q    <= 1'b0;
      n_words <= 0;
    end
    else if (tx_valid && tx_ready)
    begin
      word    <= hi_q ? {tx_byte, word[7:0]} : {8'h00, tx_byte};
      n_words <= n_words + (hi_q ? 1 : 0);
      hi_q    <= !hi_q;
    end
  end
endmodule
`default_nettype wire

// File: dv/mcsf_bank_tb_top.sv
// Purpose: Self-checking bench of the status flag bank.
// Assumes: Inputs change on the falling clock edge.
// Notes: Expected words come from an integer model of the flags.
`timescale 1ns/1ps
`default_nettype none
module mcsf_bank_tb_top;
  logic        clock, rst_n, stop_cmd, go_cmd, speed_cmd, safe_start_enable, safe_start_cond_met;
  logic        get_var, tx_ready, tx_valid, var_unknown, temp_reducing, max_speed_clamp;
  logic        start_speed_clamp, usb_kill, motor_enable, stall;
  logic [15:0] speed_value, decel_step, target_speed, motor_speed, word, sticky;
  logic [7:0]  get_var_id, tx_byte;
  logic [9:0]  error_sources;
  logic [5:1]  serial_error_pulse;
  logic [3:0]  channel_kill;
  logic [31:0] r, seed = 32'h3a1ecc48;
  int          n_errors = 0, num_checks = 0, n_words, i, k;
  initial clock = 1'b0;
  always #10 clock = ~clock;
  mcsf_bank mcsf_bank_i (.clock, .rst_n, .stop_cmd, .go_cmd, .speed_cmd, .speed_value, .safe_start_enable,
    .safe_start_cond_met, .decel_step, .get_var, .get_var_id, .tx_ready, .tx_valid, .tx_byte, .var_unknown,
    .error_sources, .serial_error_pulse, .temp_reducing, .max_speed_clamp, .start_speed_clamp,
    .channel_kill, .usb_kill, .motor_enable, .target_speed, .motor_speed);
  mcsf_host_model mcsf_host_model_i (.clock, .rst_n, .tx_valid, .tx_byte, .stall, .tx_ready, .word, .n_words);
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic tk(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // One get request, then the word the host assembled, masked where a bit is left open.
  task automatic rd(input logic [7:0] id, input logic [15:0] exp, input logic [15:0] m);
    int n0;
    n0         = n_words;
    get_var    = 1'b1;
    get_var_id = id;
    r          = rnd();
    tk(r[2] ? 2 : 1);
    get_var = 1'b0;
    for (k = 0; k < 99 && n_words == n0; k++)
    begin
      r     = rnd();
      stall = r[0] & r[1];
      tk(1);
    end
    stall = 1'b0;
    chk("read wait", 16'h0000, 16'(k == 99));
    if (k == 99)
      tally_and_finish();
    chk("word", exp, word & m);
    tk(1);
  endtask
  task automatic wait_speed(input logic [15:0] v);
    for (k = 0; k < 999 && motor_speed !== v; k++)
      tk(1);
    chk("speed wait", 16'h0000, 16'(k == 999));
    if (k == 999)
      tally_and_finish();
  endtask
  task automatic send_go();
    go_cmd = 1'b1;
    tk(1);
    go_cmd = 1'b0;
    tk(3);
  endtask
  initial
  begin
    {rst_n, stop_cmd, go_cmd, speed_cmd, get_var, stall, temp_reducing, max_speed_clamp} = 8'h00;
    {start_speed_clamp, usb_kill, channel_kill, error_sources, serial_error_pulse} = 21'h0;
    {speed_value, get_var_id} = 24'h0;
    {safe_start_enable, safe_start_cond_met} = 2'h3;
    decel_step = 16'h0010;
    tk(12);
    rst_n = 1'b1;
    tk(1);
    rd(8'h00, 16'h0001, 16'hffff);
    rd(8'h03, 16'h0001, 16'hffff);
    send_go();
    chk("motor_enable", 16'h0001, 16'(motor_enable));
    sticky = 16'h0001;
    for (i = 0; i < 4; i++)
    begin
      r             = rnd() | 32'h2;
      error_sources = r[9:0];
      sticky        = sticky | (r[15:0] & 16'h03fe);
      tk(3);
      chk("motor_enable", 16'h0000, 16'(motor_enable));
      rd(8'h00, r[15:0] & 16'h03fe, 16'hfffe);
    end
    error_sources = 10'h000;
    tk(3);
    send_go();
    rd(8'h01, sticky, 16'hffff);
    rd(8'h01, 16'h0000, 16'hffff);
    $display("test error words done");
    r = rnd();
    {usb_kill, channel_kill, start_speed_clamp, max_speed_clamp, temp_reducing} = r[7:0];
    tk(3);
    rd(8'h03, {6'h00, r[7:3], 1'b0, r[2:0], 1'b0}, 16'hffff);
    {usb_kill, channel_kill, start_speed_clamp, max_speed_clamp, temp_reducing} = 8'h00;
    tk(3);
    rd(8'h03, 16'h0000, 16'hffff);
    $display("test limit word done");
    speed_value = 16'h0100;
    speed_cmd   = 1'b1;
    tk(1);
    speed_cmd = 1'b0;
    wait_speed(16'h0100);
    stop_cmd = 1'b1;
    tk(1);
    stop_cmd = 1'b0;
    chk("target_speed", 16'h0000, target_speed);
    wait_speed(16'h0000);
    chk("ramp cycles", 16'h0001, 16'(k >= 15));
    rd(8'h00, 16'h0001, 16'hffff);
    safe_start_cond_met = 1'b0;
    send_go();
    chk("motor_enable", 16'h0000, 16'(motor_enable));
    safe_start_cond_met = 1'b1;
    send_go();
    chk("motor_enable", 16'h0001, 16'(motor_enable));
    safe_start_enable = 1'b0;
    stop_cmd          = 1'b1;
    tk(1);
    stop_cmd = 1'b0;
    tk(3);
    chk("motor_enable", 16'h0001, 16'(motor_enable));
    rd(8'h00, 16'h0000, 16'hffff);
    safe_start_enable = 1'b1;
    $display("test stop done");
    for (i = 0; i < 2; i++)
    begin
      get_var    = 1'b1;
      get_var_id = i ? 8'hff : 8'h04;
      tk(1);
      get_var = 1'b0;
      chk("var_unknown", 16'h0001, 16'(var_unknown));
      tk(3);
      chk("tx_valid", 16'h0000, 16'(tx_valid));
    end
    for (i = 1; i < 6; i++)
    begin
      serial_error_pulse = 5'(1 << (i - 1));
      tk(1);
      serial_error_pulse = 5'h00;
      tk(1);
    end
    rd(8'h02, 16'h003e, 16'hffff);
    rd(8'h02, 16'h0000, 16'hffff);
    rd(8'h01, 16'h0004, 16'h0004);
    $display("test serial log done");
    rst_n = 1'b0;
    tk(2);
    rst_n = 1'b1;
    tk(1);
    chk("motor_enable", 16'h0000, 16'(motor_enable));
    rd(8'h00, 16'h0001, 16'hffff);
    rd(8'h01, 16'h0001, 16'hffff);
    $display("test reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
